// File: ost_pkg.sv
// Constants and types shared by the oscillation stabilization timer.
// Assumes one 200 MHz clock, one count per main-oscillator period.
package ost_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_SEL  = 16'hffa4;
  localparam logic [15:0] ADDR_STAT = 16'hffa3;
  localparam logic [7:0]  SEL_RESET = 8'h05;
  localparam int          SEL_MSB   = 2;
  localparam int          STAT_W    = 5;

  // ----------------------------------------
  // Select codes and wait lengths (main-oscillator periods)
  // ----------------------------------------
  localparam logic [2:0]  CODE_W11  = 3'h1;
  localparam logic [2:0]  CODE_W13  = 3'h2;
  localparam logic [2:0]  CODE_W14  = 3'h3;
  localparam logic [2:0]  CODE_W15  = 3'h4;
  localparam logic [2:0]  CODE_W16  = 3'h5;
  localparam int          CNT_W     = 17;
  localparam logic [16:0] WAIT_11   = 17'h00800;
  localparam int          DEF_W13   = 8192;
  localparam int          DEF_W14   = 16384;
  localparam int          DEF_W15   = 32768;
  localparam int          DEF_W16   = 65536;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_STOP     = 3'h1,
    ST_WAIT_OSC = 3'h2,
    ST_STAB     = 3'h3,
    ST_HALT     = 3'h4
  } ost_state_e;

  typedef enum logic [1:0] {
    SRC_MAIN_XTAL = 2'h0,
    SRC_INT_HS    = 2'h1,
    SRC_SUB       = 2'h2
  } ost_clk_src_e;

endpackage

// File: ost_stab_counter.sv
// Stabilization up-counter: clears, then counts while enabled up to a limit.
// Assumes limit is held steady by the caller for the whole count.
`timescale 1ns/10ps
module ost_stab_counter (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clear,
  input  wire logic              run,
  input  wire logic [16:0]       limit,
  output logic      [16:0]       count_r,
  output logic                   done
);

  logic [16:0] count_nxt;

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = 17'h00000;
    end else if (run && (count_r < limit)) begin
      count_nxt = count_r + 17'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= 17'h00000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign done = (count_r == limit);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cnt_never_over_a: assert property (!clear && run |=> count_r <= $past(limit))
    else $error("Counter ran past its limit");

  cnt_holds_idle_a: assert property (!clear && !run |=> count_r == $past(count_r))
    else $error("Counter moved while not enabled");

endmodule

// File: ost_timer.sv
// Oscillation stabilization timer with standby mode sequencing.
// Assumes CPU event strobes are one-cycle pulses on clk; osc_running is a pin.
//
// Functional notes
// - The select register sits at address FFA4H, resets to 05H and is read/write.
// - The select field offers waits of 2^11, 2^13, 2^14, 2^15 and 2^16 cycles only.
// - The counter counts up from its start and stops at the selected wait length.
// - After STOP release the status counter never shows progress beyond the wait.
// - Counting starts only once the oscillator runs; the start-up delay is not counted.
// - HALT is entered on the HALT instruction only from RUN, so not while an off-crystal CPU runs during the wait.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module ost_timer #(
  parameter int WAIT_13 = ost_pkg::DEF_W13,
  parameter int WAIT_14 = ost_pkg::DEF_W14,
  parameter int WAIT_15 = ost_pkg::DEF_W15,
  parameter int WAIT_16 = ost_pkg::DEF_W16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata_r,
  input  wire logic              stop_req,
  input  wire logic              stop_release,
  input  wire logic              halt_req,
  input  wire logic              halt_release,
  input  wire logic [1:0]        cpu_clk_src,
  input  wire logic              osc_running,
  output logic                   osc_enable_r,
  output logic                   clk_stable_r,
  output logic                   cpu_run_r,
  output logic                   stop_mode_r,
  output logic                   halt_mode_r
);

  // ----------------------------------------
  // Wait-length table
  // ----------------------------------------
  localparam logic [16:0] W13 = 17'(WAIT_13);
  localparam logic [16:0] W14 = 17'(WAIT_14);
  localparam logic [16:0] W15 = 17'(WAIT_15);
  localparam logic [16:0] W16 = 17'(WAIT_16);
  localparam logic [ost_pkg::STAT_W-1:0][16:0] THR = {W16, W15, W14, W13, ost_pkg::WAIT_11};

  // Prohibited codes fall back to the longest wait, the safe side for a crystal
  function automatic logic [16:0] wait_len(input logic [2:0] code);
    logic [16:0] len;
    len = W16;
    case (code)
      ost_pkg::CODE_W11: len = ost_pkg::WAIT_11;
      ost_pkg::CODE_W13: len = W13;
      ost_pkg::CODE_W14: len = W14;
      ost_pkg::CODE_W15: len = W15;
      ost_pkg::CODE_W16: len = W16;
      default:           len = W16;
    endcase
    return len;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ost_pkg::ost_state_e           state_r;
  ost_pkg::ost_state_e           state_nxt;
  logic [ost_pkg::SEL_MSB:0]     sel_r;
  logic [16:0]                   lim_r;
  logic [16:0]                   cnt;
  logic                          cnt_done;
  logic                          cnt_clear;
  logic                          cnt_run;
  logic [ost_pkg::STAT_W-1:0]    stat_r;
  logic [ost_pkg::STAT_W-1:0]    stat_nxt;
  logic                          osc_meta_r;
  logic                          osc_sync_r;
  logic                          sel_hit;
  logic                          stat_hit;
  logic                          stop_go;
  logic                          xtal_cpu;

  assign sel_hit  = (reg_addr == ost_pkg::ADDR_SEL);
  assign stat_hit = (reg_addr == ost_pkg::ADDR_STAT);
  assign stop_go  = (state_r == ost_pkg::ST_RUN) && stop_req;
  assign xtal_cpu = (cpu_clk_src == ost_pkg::SRC_MAIN_XTAL);

  // ----------------------------------------
  // Oscillator-running synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_running;
      osc_sync_r <= osc_meta_r;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Writes during a wait are accepted; the wait length is frozen at STOP entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_r <= ost_pkg::SEL_RESET[ost_pkg::SEL_MSB:0];
    end else if (reg_wr && sel_hit) begin
      sel_r <= reg_wdata[ost_pkg::SEL_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd && sel_hit) begin
      reg_rdata_r <= {5'h00, sel_r};
    end else if (reg_rd && stat_hit) begin
      reg_rdata_r <= {3'h0, stat_r};
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------
  // Standby state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ost_pkg::ST_RUN: begin
        if (stop_req) begin
          state_nxt = ost_pkg::ST_STOP;
        end else if (halt_req) begin
          state_nxt = ost_pkg::ST_HALT;
        end
      end
      ost_pkg::ST_STOP: begin
        if (stop_release) begin
          state_nxt = ost_pkg::ST_WAIT_OSC;
        end
      end
      ost_pkg::ST_WAIT_OSC: begin
        if (osc_sync_r) begin
          state_nxt = ost_pkg::ST_STAB;
        end
      end
      ost_pkg::ST_STAB: begin
        if (cnt_done) begin
          state_nxt = ost_pkg::ST_RUN;
        end
      end
      ost_pkg::ST_HALT: begin
        if (halt_release) begin
          state_nxt = ost_pkg::ST_RUN;
        end
      end
      default: state_nxt = ost_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ost_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Wait length snapshot and counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lim_r <= W16;
    end else if (stop_go) begin
      lim_r <= wait_len(sel_r);
    end
  end

  assign cnt_clear = stop_go;
  assign cnt_run   = (state_r == ost_pkg::ST_STAB) && osc_sync_r;

  ost_stab_counter u_cnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (cnt_clear),
    .run     (cnt_run),
    .limit   (lim_r),
    .count_r (cnt),
    .done    (cnt_done)
  );

  // ----------------------------------------
  // Status counter: one bit per threshold passed
  // ----------------------------------------
  // The count halts at the selected wait, so longer thresholds stay clear
  genvar gi;
  generate
    for (gi = 0; gi < ost_pkg::STAT_W; gi++) begin : g_stat
      assign stat_nxt[gi] = stop_go ? 1'b0 : (stat_r[gi] | (cnt >= THR[gi]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ----------------------------------------
  // Clock and CPU control outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_enable_r <= 1'b1;
      clk_stable_r <= 1'b1;
    end else if (state_nxt == ost_pkg::ST_STOP) begin
      osc_enable_r <= 1'b0;
      clk_stable_r <= 1'b0;
    end else if (state_nxt == ost_pkg::ST_WAIT_OSC) begin
      osc_enable_r <= 1'b1;
    end else if ((state_r == ost_pkg::ST_STAB) && cnt_done) begin
      clk_stable_r <= 1'b1;
    end
  end

  // Off the crystal the CPU restarts at once while the count carries on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_run_r <= 1'b1;
    end else begin
      case (state_nxt)
        ost_pkg::ST_RUN:      cpu_run_r <= 1'b1;
        ost_pkg::ST_WAIT_OSC,
        ost_pkg::ST_STAB:     cpu_run_r <= cpu_run_r | !xtal_cpu;
        default:              cpu_run_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_mode_r <= 1'b0;
      halt_mode_r <= 1'b0;
    end else begin
      stop_mode_r <= (state_nxt == ost_pkg::ST_STOP);
      halt_mode_r <= (state_nxt == ost_pkg::ST_HALT);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [ost_pkg::STAT_W-1:0] stat_allowed;
  always_comb begin
    stat_allowed = '0;
    for (int i = 0; i < ost_pkg::STAT_W; i++) begin
      stat_allowed[i] = (THR[i] <= lim_r);
    end
  end

  sequence s_stop_entry;
    (state_r == ost_pkg::ST_RUN) && stop_req;
  endsequence

  sequence s_stab_end;
    (state_r == ost_pkg::ST_STAB) && cnt_done;
  endsequence

  sel_reset_a: assert property ($rose(rst_n) |-> sel_r == 3'h5)
    else $error("Select register not 05H after reset");

  sel_read_a: assert property (reg_rd && sel_hit |=> reg_rdata_r == {5'h00, $past(sel_r)})
    else $error("Select register read returned wrong value");

  upper_zero_a: assert property (reg_rd && sel_hit |=> reg_rdata_r[7:3] == 5'h00)
    else $error("Reserved select bits read non-zero");

  wait_table_a: assert property (s_stop_entry |=> (lim_r == ost_pkg::WAIT_11)
      || (lim_r == W13) || (lim_r == W14) || (lim_r == W15) || (lim_r == W16))
    else $error("Wait length outside the five legal values");

  code_map_a: assert property ((s_stop_entry and (sel_r == ost_pkg::CODE_W11))
      |=> lim_r == ost_pkg::WAIT_11)
    else $error("Code 001 did not select the 2^11 wait");

  stab_finish_a: assert property (s_stab_end |=> (state_r == ost_pkg::ST_RUN)
      && clk_stable_r && (cnt == $past(lim_r)))
    else $error("Wait did not finish at its selected length");

  stat_cap_a: assert property ((stat_r & ~stat_allowed) == '0)
    else $error("Status shows progress beyond the selected wait");

  osc_gate_a: assert property ((state_r == ost_pkg::ST_WAIT_OSC) |-> cnt == 17'h00000)
    else $error("Count advanced before the oscillator ran");

  halt_enter_a: assert property ((state_r == ost_pkg::ST_RUN) && halt_req && !stop_req
      |=> halt_mode_r && !cpu_run_r)
    else $error("HALT not entered on request");

endmodule

// File: osc_stabilization_timer_tb.sv
// Self-checking bench for the oscillation stabilization timer.
// Assumes ost_timer and ost_pkg are compiled first; one 200 MHz clock.
`timescale 1ns/10ps
module osc_stabilization_timer_tb;
  // ----------------------------------------
  // Shortened waits keep the run small
  // ----------------------------------------
  localparam int W11 = 2048;
  localparam int W13 = 2100;
  localparam int W14 = 2200;
  localparam int W15 = 2300;
  localparam int W16 = 2400;

  logic        clk;
  logic        rst_n;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata_r;
  logic        stop_req;
  logic        stop_release;
  logic        halt_req;
  logic        halt_release;
  logic [1:0]  cpu_clk_src;
  logic        osc_running;
  logic        osc_enable_r;
  logic        clk_stable_r;
  logic        cpu_run_r;
  logic        stop_mode_r;
  logic        halt_mode_r;
  int          err_total;
  int          compares;

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  ost_timer #(.WAIT_13(W13), .WAIT_14(W14), .WAIT_15(W15), .WAIT_16(W16)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .stop_req(stop_req), .stop_release(stop_release), .halt_req(halt_req),
    .halt_release(halt_release), .cpu_clk_src(cpu_clk_src), .osc_running(osc_running),
    .osc_enable_r(osc_enable_r), .clk_stable_r(clk_stable_r), .cpu_run_r(cpu_run_r),
    .stop_mode_r(stop_mode_r), .halt_mode_r(halt_mode_r));

  // ----------------------------------------
  // Clock, closing and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Scenarios need about 34k cycles; allow over twice that
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd(ost_pkg::ADDR_SEL, d);
    `CHK(d, 8'h05)
    @(posedge clk);
    #1;
    `CHK(reg_rdata_r, 8'h00)
    rd(ost_pkg::ADDR_STAT, d);
    `CHK(d, 8'h00)
    wr(ost_pkg::ADDR_SEL, 8'hff);
    rd(ost_pkg::ADDR_SEL, d);
    `CHK(d, 8'h07)
    wr(ost_pkg::ADDR_STAT, 8'haa);
    rd(ost_pkg::ADDR_STAT, d);
    `CHK(d, 8'h00)
    rd(16'hffa5, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_halt(input logic [1:0] s);
    @(posedge clk);
    cpu_clk_src <= s;
    halt_req    <= 1'b1;
    @(posedge clk);
    halt_req     <= 1'b0;
    stop_release <= 1'b1;
    #1;
    `CHK(halt_mode_r, 1'b1)
    `CHK(cpu_run_r, 1'b0)
    @(posedge clk);
    stop_release <= 1'b0;
    halt_release <= 1'b1;
    @(posedge clk);
    halt_release <= 1'b0;
    #1;
    `CHK(stop_mode_r, 1'b0)
    `CHK(halt_mode_r, 1'b0)
    `CHK(cpu_run_r, 1'b1)
  endtask

  // Select code, CPU source, expected wait and status mask
  task automatic t_stop(input logic [2:0] c, input logic [1:0] s, input int w,
                        input logic [7:0] m);
    int         n;
    logic [7:0] d;
    wr(ost_pkg::ADDR_SEL, {5'h00, c});
    cpu_clk_src <= s;
    @(posedge clk);
    stop_req    <= 1'b1;
    osc_running <= 1'b0;
    @(posedge clk);
    stop_req <= 1'b0;
    #1;
    `CHK(stop_mode_r, 1'b1)
    `CHK(clk_stable_r, 1'b0)
    `CHK(osc_enable_r, 1'b0)
    `CHK(cpu_run_r, 1'b0)
    @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    #1;
    `CHK(stop_mode_r, 1'b0)
    `CHK(osc_enable_r, 1'b1)
    `CHK(cpu_run_r, (s != 2'h0))
    // Oscillator start-up longer than any wait must not be counted
    repeat (2500) @(posedge clk);
    #1;
    `CHK(clk_stable_r, 1'b0)
    @(posedge clk);
    osc_running <= 1'b1;
    n = 0;
    // Select register is left alone for the whole wait
    while (clk_stable_r !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK((n >= w + 3 && n <= w + 5), 1'b1)
    `CHK(cpu_run_r, 1'b1)
    rd(ost_pkg::ADDR_STAT, d);
    `CHK(d, m)
    repeat (50) @(posedge clk);
    rd(ost_pkg::ADDR_STAT, d);
    `CHK(d, m)
    rd(ost_pkg::ADDR_SEL, d);
    `CHK(d, {5'h00, c})
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total    = 0;
    compares     = 0;
    rst_n        = 1'b0;
    reg_addr     = 16'h0000;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    stop_req     = 1'b0;
    stop_release = 1'b0;
    halt_req     = 1'b0;
    halt_release = 1'b0;
    cpu_clk_src  = 2'h0;
    osc_running  = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    for (int s = 0; s < 3; s++) begin
      t_halt(s[1:0]);
    end
    t_stop(ost_pkg::CODE_W11, 2'h0, W11, 8'h01);
    t_stop(ost_pkg::CODE_W13, 2'h0, W13, 8'h03);
    t_stop(ost_pkg::CODE_W14, 2'h0, W14, 8'h07);
    t_stop(ost_pkg::CODE_W15, 2'h0, W15, 8'h0f);
    t_stop(ost_pkg::CODE_W16, 2'h0, W16, 8'h1f);
    t_stop(3'h0, 2'h0, W16, 8'h1f);
    // Internal clock: longest wait covers every status point
    t_stop(ost_pkg::CODE_W16, 2'h1, W16, 8'h1f);
    wrap_up();
  end
endmodule
